// >>> verilog/switch_id_and_start_control.sv
// Purpose: Chip identity, start control, default fill and checked EEPROM load
// Assumes: Serial access port and EEPROM byte reader run on clk_i
// Notes:   Straps are pins and are synchronised before use
`timescale 1ns/1ps
`include "switch_id_regs.svh"

module switch_id_and_start_control
	import switch_id_pkg::*;
#(
	parameter logic [7:0] FAMILY_CODE         = 8'hA7,  // Arbitrary value
	parameter logic [3:0] SERIES_CODE         = 4'h5,   // Arbitrary value
	parameter logic [2:0] REVISION_CODE       = 3'h3,   // Arbitrary value
	parameter int         LOAD_TIMEOUT_CYCLES = `LOAD_TIME_MAX_CYCLES
) (
	input  wire logic           clk_i,
	input  wire logic           reset_n_i,
	input  wire logic           ce_i,
	input  wire logic [1:0]     serial_mode_straps_i,
	input  wire access_req_type host_req_i,
	output logic                host_ready_o,
	output access_rsp_type      host_rsp_o,
	output ee_req_type          ee_req_o,
	input  wire logic           ee_ack_i,
	input  wire logic [7:0]     ee_data_i,
	input  wire logic           ee_absent_i,
	output logic                switch_enable_o,
	output logic                eeprom_applied_o
);

	localparam int TIMER_W = $clog2(LOAD_TIMEOUT_CYCLES + 1);

	typedef enum logic [1:0] {ST_INIT, ST_LOAD, ST_RUN} state_type;

	// ----------------------------------------------------------------
	// Strap synchroniser
	// ----------------------------------------------------------------
	logic [1:0] strap_meta_ff;
	logic [1:0] strap_sync_ff;

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			strap_meta_ff <= 2'h0;
			strap_sync_ff <= 2'h0;
		end else if (ce_i) begin
			strap_meta_ff <= serial_mode_straps_i;
			strap_sync_ff <= strap_meta_ff;
		end
	end

	// ----------------------------------------------------------------
	// Region decode
	// ----------------------------------------------------------------
	function automatic region_type decode_region(input logic [6:0] a);
		region_type r;
		r = REGION_CHIP_ID;
		if (a >= `ATEST_STAT_ADDR)                r = REGION_ATEST_STAT;
		else if (a >= `ATEST_CTRL_FIRST)          r = REGION_ATEST_CTRL;
		else if (a >= `DTEST_CTRL_FIRST)          r = REGION_DTEST_CTRL;
		else if (a >= `DTEST_STAT_FIRST)          r = REGION_DTEST_STAT;
		else if (a >= `IND_DATA_FIRST)            r = REGION_IND_DATA;
		else if (a >= `IND_CTRL_FIRST)            r = REGION_IND_CTRL;
		else if (a >= `MAC_FIRST)                 r = REGION_MAC;
		else if (a >= `TOS_FIRST)                 r = REGION_TOS;
		else if (a >= `PORT_FIRST) begin
			if (a[3:0] >= `PORT_STATUS_OFS)       r = REGION_PORT_STATUS;
			else                                  r = REGION_PORT_CTRL;
		end
		else if (a >= `RSVD_FIRST)                r = REGION_RESERVED;
		else if (a >= `GLOBAL_FIRST)              r = REGION_GLOBAL;
		return r;
	endfunction

	// Port number 1..5 for port blocks, zero elsewhere
	function automatic logic [2:0] decode_port(input logic [6:0] a);
		logic [2:0] p;
		p = 3'h0;
		if (a >= `PORT_FIRST && a <= `PORT_LAST) p = a[6:4];
		return p;
	endfunction

	// ----------------------------------------------------------------
	// Control state
	// ----------------------------------------------------------------
	state_type          state_ff,      nxt_state;
	logic [6:0]         addr_cnt_ff,   nxt_addr_cnt;
	logic [TIMER_W-1:0] timer_ff,      nxt_timer;
	logic [1:0]         strap_mode_ff, nxt_strap_mode;
	logic               start_ff,      nxt_start;
	logic               run_ff,        nxt_run;
	logic               id_ok_ff,      nxt_id_ok;
	logic               mem_we;
	logic [6:0]         mem_waddr;
	logic [7:0]         mem_wdata;
	logic               host_take;
	logic               host_mem_addr;

	assign host_take     = ce_i && state_ff == ST_RUN;
	// Host writes to identity and reserved bytes never reach storage
	assign host_mem_addr = host_req_i.addr >= `GLOBAL_FIRST
		&& !(host_req_i.addr >= `RSVD_FIRST && host_req_i.addr <= `RSVD_LAST);

	always_comb begin
		nxt_state      = state_ff;
		nxt_addr_cnt   = addr_cnt_ff;
		nxt_timer      = timer_ff;
		nxt_strap_mode = strap_mode_ff;
		nxt_start      = start_ff;
		nxt_id_ok      = id_ok_ff;
		mem_we         = 1'h0;
		mem_waddr      = addr_cnt_ff;
		mem_wdata      = `DEFAULT_BYTE;
		unique case (state_ff)
			ST_INIT: begin
				// Fill defaults; also gives the strap synchroniser time to settle
				mem_we = 1'h1;
				if (addr_cnt_ff == `LAST_ADDR) begin
					nxt_strap_mode = strap_sync_ff;
					nxt_addr_cnt   = 7'h00;
					nxt_timer      = '0;
					nxt_state      = (strap_sync_ff == `STRAP_EEPROM) ? ST_LOAD : ST_RUN;
				end else begin
					nxt_addr_cnt = addr_cnt_ff + 7'h01;
				end
			end
			ST_LOAD: begin
				nxt_timer = timer_ff + TIMER_W'(1);
				if (ee_absent_i || timer_ff == TIMER_W'(LOAD_TIMEOUT_CYCLES - 1)) begin
					nxt_state = ST_RUN;
				end else if (ee_ack_i) begin
					nxt_addr_cnt = addr_cnt_ff + 7'h01;
					if (addr_cnt_ff == `REG_FAMILY_ADDR) begin
						if (ee_data_i != FAMILY_CODE) nxt_state = ST_RUN;
					end else if (addr_cnt_ff == `REG_SERIES_ADDR) begin
						if (ee_data_i[`SERIES_MSB:`SERIES_LSB] != SERIES_CODE) begin
							nxt_state = ST_RUN;
						end else begin
							nxt_id_ok = 1'h1;
						end
					end else begin
						mem_we    = id_ok_ff;
						mem_wdata = ee_data_i;
						if (addr_cnt_ff == `EE_BYTE_COUNT - 7'h01) nxt_state = ST_RUN;
					end
				end
			end
			ST_RUN: begin
				if (host_req_i.wr) begin
					if (host_req_i.addr == `REG_SERIES_ADDR) begin
						nxt_start = host_req_i.wdata[`START_BIT];
					end
					mem_we    = host_mem_addr;
					mem_waddr = host_req_i.addr;
					mem_wdata = host_req_i.wdata;
				end
			end
		endcase
		// In SPI and reserved strap modes enable follows the start bit in the same cycle it is stored
		nxt_run = 1'h0;
		if (nxt_state == ST_RUN) begin
			unique case (nxt_strap_mode)
				`STRAP_EEPROM: nxt_run = 1'h1;
				`STRAP_TEST:   nxt_run = 1'h0;
				default:       nxt_run = nxt_start;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			state_ff      <= ST_INIT;
			addr_cnt_ff   <= `GLOBAL_FIRST;
			timer_ff      <= '0;
			strap_mode_ff <= `STRAP_TEST;
			start_ff      <= `START_RESET;
			run_ff        <= 1'h0;
			id_ok_ff      <= 1'h0;
		end else if (ce_i) begin
			state_ff      <= nxt_state;
			addr_cnt_ff   <= nxt_addr_cnt;
			timer_ff      <= nxt_timer;
			strap_mode_ff <= nxt_strap_mode;
			start_ff      <= nxt_start;
			run_ff        <= nxt_run;
			id_ok_ff      <= nxt_id_ok;
		end
	end

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	logic [7:0] mem_rdata;

	config_byte_mem #(
		.ADDR_W (7),
		.DATA_W (8)
	) u_mem (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.ce_i      (ce_i),
		.wr_en_i   (mem_we),
		.wr_addr_i (mem_waddr),
		.wr_data_i (mem_wdata),
		.rd_en_i   (host_take && host_req_i.rd),
		.rd_addr_i (host_req_i.addr),
		.rd_data_o (mem_rdata)
	);

	// ----------------------------------------------------------------
	// Read response
	// ----------------------------------------------------------------
	logic       rvalid_ff,  nxt_rvalid;
	logic       sel_mem_ff, nxt_sel_mem;
	logic [7:0] id_data_ff, nxt_id_data;
	region_type region_ff,  nxt_region;
	logic [2:0] port_ff,    nxt_port;

	always_comb begin
		nxt_rvalid  = 1'h0;
		nxt_sel_mem = sel_mem_ff;
		nxt_id_data = id_data_ff;
		nxt_region  = region_ff;
		nxt_port    = port_ff;
		if (host_take && host_req_i.rd) begin
			nxt_rvalid  = 1'h1;
			nxt_sel_mem = host_mem_addr;
			nxt_region  = decode_region(host_req_i.addr);
			nxt_port    = decode_port(host_req_i.addr);
			nxt_id_data = 8'h00;
			if (host_req_i.addr == `REG_FAMILY_ADDR) begin
				nxt_id_data = FAMILY_CODE;
			end else if (host_req_i.addr == `REG_SERIES_ADDR) begin
				nxt_id_data = {SERIES_CODE, REVISION_CODE, start_ff};
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			rvalid_ff  <= 1'h0;
			sel_mem_ff <= 1'h0;
			id_data_ff <= 8'h00;
			region_ff  <= REGION_CHIP_ID;
			port_ff    <= 3'h0;
		end else if (ce_i) begin
			rvalid_ff  <= nxt_rvalid;
			sel_mem_ff <= nxt_sel_mem;
			id_data_ff <= nxt_id_data;
			region_ff  <= nxt_region;
			port_ff    <= nxt_port;
		end
	end

	assign host_ready_o     = state_ff == ST_RUN;
	assign host_rsp_o       = '{rvalid: rvalid_ff,
		rdata: sel_mem_ff ? mem_rdata : id_data_ff, region: region_ff, port: port_ff};
	assign ee_req_o         = '{valid: state_ff == ST_LOAD, addr: addr_cnt_ff};
	assign switch_enable_o  = run_ff;
	assign eeprom_applied_o = id_ok_ff;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	sequence s_read(logic [6:0] a);
		host_take && host_req_i.rd && host_req_i.addr == a;
	endsequence

	sequence s_load_byte(logic [6:0] a);
		ce_i && state_ff == ST_LOAD && ee_ack_i && !ee_absent_i && addr_cnt_ff == a
			&& timer_ff != TIMER_W'(LOAD_TIMEOUT_CYCLES - 1);
	endsequence

	a_family_read: assert property (s_read(`REG_FAMILY_ADDR) |=>
		host_rsp_o.rvalid && host_rsp_o.rdata == FAMILY_CODE)
		else $error("family code read wrong");
	a_series_read: assert property (s_read(`REG_SERIES_ADDR) |=>
		host_rsp_o.rdata[7:1] == {SERIES_CODE, REVISION_CODE}
		&& host_rsp_o.rdata[0] == $past(start_ff))
		else $error("series or revision read wrong");
	a_start_runs: assert property (state_ff == ST_RUN && start_ff
		&& (strap_mode_ff == `STRAP_SPI || strap_mode_ff == `STRAP_RSVD) |-> switch_enable_o)
		else $error("start bit did not run switch");
	a_start_holds: assert property (!start_ff
		&& (strap_mode_ff == `STRAP_SPI || strap_mode_ff == `STRAP_RSVD) |-> !switch_enable_o)
		else $error("switch ran without start bit");
	a_auto_start: assert property (state_ff == ST_RUN
		&& strap_mode_ff == `STRAP_EEPROM |-> switch_enable_o && host_ready_o)
		else $error("eeprom mode did not start");
	a_absent_default: assert property (ce_i && state_ff == ST_LOAD
		&& ee_absent_i && !id_ok_ff |=> state_ff == ST_RUN && !eeprom_applied_o)
		else $error("absent eeprom not handled");
	a_family_check: assert property (s_load_byte(`REG_FAMILY_ADDR)
		&& ee_data_i != FAMILY_CODE |=> state_ff == ST_RUN ##0 !id_ok_ff)
		else $error("bad family byte accepted");
	a_load_guard: assert property (mem_we && state_ff == ST_LOAD |-> id_ok_ff
		&& addr_cnt_ff >= `GLOBAL_FIRST && addr_cnt_ff < `EE_BYTE_COUNT)
		else $error("unchecked eeprom byte stored");
	a_load_length: assert property (s_load_byte(`EE_BYTE_COUNT - 7'h01)
		|=> state_ff == ST_RUN ##1 ee_req_o.valid == 1'h0)
		else $error("load length wrong");
	a_port_decode: assert property (host_take && host_req_i.rd
		&& host_req_i.addr == `PORT_FIRST |=> host_rsp_o.region == REGION_PORT_CTRL
		&& host_rsp_o.port == 3'h1)
		else $error("port decode wrong");
	a_reserved_zero: assert property (host_take && host_req_i.rd
		&& host_req_i.addr >= `RSVD_FIRST && host_req_i.addr <= `RSVD_LAST
		|=> host_rsp_o.rdata == 8'h00)
		else $error("reserved byte not zero");
	a_start_reset: assert property ($past(!reset_n_i) |-> !start_ff
		&& !switch_enable_o)
		else $error("start bit not cleared by reset");

endmodule

// >>> verilog/switch_id_regs.svh
// Purpose: Offsets, field positions, decode bounds and timing counts of the ID/start block
// Assumes: 7-bit byte addresses, 8-bit register data
// Notes:   Definitions only
`ifndef SWITCH_ID_REGS_SVH
`define SWITCH_ID_REGS_SVH

// ----------------------------------------------------------------
// Identification registers
// ----------------------------------------------------------------
`define REG_FAMILY_ADDR     7'h00
`define REG_SERIES_ADDR     7'h01
`define SERIES_MSB          7
`define SERIES_LSB          4
`define REV_MSB             3
`define REV_LSB             1
`define START_BIT           0
`define START_RESET         1'h0

// ----------------------------------------------------------------
// Address map bounds
// ----------------------------------------------------------------
`define GLOBAL_FIRST        7'h02
`define RSVD_FIRST          7'h0C
`define RSVD_LAST           7'h0F
`define PORT_FIRST          7'h10
`define PORT_LAST           7'h5F
`define PORT_STATUS_OFS     4'hE
`define TOS_FIRST           7'h60
`define MAC_FIRST           7'h68
`define IND_CTRL_FIRST      7'h6E
`define IND_DATA_FIRST      7'h70
`define DTEST_STAT_FIRST    7'h79
`define DTEST_CTRL_FIRST    7'h7B
`define ATEST_CTRL_FIRST    7'h7D
`define ATEST_STAT_ADDR     7'h7F
`define LAST_ADDR           7'h7F

// ----------------------------------------------------------------
// Strap settings, load sequence and timing
// ----------------------------------------------------------------
`define STRAP_EEPROM        2'h0
`define STRAP_RSVD          2'h1
`define STRAP_SPI           2'h2
`define STRAP_TEST          2'h3
`define EE_BYTE_COUNT       7'h6E
`define DEFAULT_BYTE        8'h00
`define CLK_PERIOD_NS       40
`define LOAD_TIME_MAX_MS    15
`define LOAD_TIME_MAX_CYCLES ((`LOAD_TIME_MAX_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// >>> verilog/switch_id_pkg.sv
// Purpose: Types shared by the ID/start block and its users
// Assumes: switch_id_regs.svh for the numbers
// Notes:   Types only
package switch_id_pkg;

	// ----------------------------------------------------------------
	// Address regions
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		REGION_CHIP_ID, REGION_GLOBAL, REGION_RESERVED, REGION_PORT_CTRL,
		REGION_PORT_STATUS, REGION_TOS, REGION_MAC, REGION_IND_CTRL,
		REGION_IND_DATA, REGION_DTEST_STAT, REGION_DTEST_CTRL,
		REGION_ATEST_CTRL, REGION_ATEST_STAT
	} region_type;

	// ----------------------------------------------------------------
	// Access port carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [6:0] addr;
		logic [7:0] wdata;
	} access_req_type;

	typedef struct packed {
		logic       rvalid;
		logic [7:0] rdata;
		region_type region;
		logic [2:0] port;
	} access_rsp_type;

	typedef struct packed {
		logic       valid;
		logic [6:0] addr;
	} ee_req_type;

endpackage

// >>> verilog/config_byte_mem.sv
// Purpose: Byte-wide register storage with registered read data
// Assumes: One write and one read port on the same clock
// Notes:   Contents have no reset; the owner fills defaults
`timescale 1ns/1ps

module config_byte_mem #(
	parameter int ADDR_W = 7,
	parameter int DATA_W = 8
) (
	input  wire logic              clk_i,
	input  wire logic              reset_n_i,
	input  wire logic              ce_i,
	input  wire logic              wr_en_i,
	input  wire logic [ADDR_W-1:0] wr_addr_i,
	input  wire logic [DATA_W-1:0] wr_data_i,
	input  wire logic              rd_en_i,
	input  wire logic [ADDR_W-1:0] rd_addr_i,
	output logic      [DATA_W-1:0] rd_data_o
);

	logic [DATA_W-1:0] mem_ff [2**ADDR_W];
	logic [DATA_W-1:0] rd_data_ff;
	logic [DATA_W-1:0] nxt_rd_data;

	// ----------------------------------------------------------------
	// Read and write
	// ----------------------------------------------------------------
	always_comb begin
		nxt_rd_data = rd_data_ff;
		if (rd_en_i) begin
			nxt_rd_data = mem_ff[rd_addr_i];
		end
	end

	always_ff @(posedge clk_i) begin
		if (ce_i && wr_en_i) begin
			mem_ff[wr_addr_i] <= wr_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			rd_data_ff <= '0;
		end else if (ce_i) begin
			rd_data_ff <= nxt_rd_data;
		end
	end

	assign rd_data_o = rd_data_ff;

endmodule

// >>> tb/eeprom_model.sv
// Purpose: Behavioural configuration EEPROM behind the load port
// Assumes: Byte reader handshake of the ID/start block, same clock
// Notes:   Data line toggles between the last byte and its inverse each cycle between acks
`timescale 1ns/1ps

module eeprom_model
	import switch_id_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       reset_n_i,
	input  wire ee_req_type ee_req_i,
	input  wire logic       present_i,
	input  wire logic [9:0] delay_i,
	input  wire logic [7:0] byte0_i,
	input  wire logic [7:0] byte1_i,
	output logic            ee_ack_o,
	output logic [7:0]      ee_data_o,
	output logic            ee_absent_o,
	output logic [7:0]      served_o,
	output logic            order_err_o
);
	logic [9:0] wait_ff;
	logic [6:0] next_ff;

	assign ee_absent_o = ~present_i;

	// One idle cycle after each ack, so the new address is seen first
	always @(posedge clk_i) begin
		if (!reset_n_i) begin
			ee_ack_o <= 1'h0;
			ee_data_o <= 8'h00;
			wait_ff <= 10'h000;
			next_ff <= 7'h00;
			served_o <= 8'h00;
			order_err_o <= 1'h0;
		end else if (ee_ack_o || !ee_req_i.valid || !present_i) begin
			ee_ack_o <= 1'h0;
			wait_ff <= 10'h000;
			ee_data_o <= ~ee_data_o;
		end else if (wait_ff == delay_i) begin
			ee_ack_o <= 1'h1;
			if (ee_req_i.addr == 7'h00) begin
				ee_data_o <= byte0_i;
			end else if (ee_req_i.addr == 7'h01) begin
				ee_data_o <= byte1_i;
			end else begin
				ee_data_o <= 8'h5A ^ {1'h0, ee_req_i.addr};
			end
			if (ee_req_i.addr != next_ff) begin
				order_err_o <= 1'h1;
			end
			next_ff <= ee_req_i.addr + 7'h01;
			served_o <= served_o + 8'h01;
		end else begin
			wait_ff <= wait_ff + 10'h001;
			ee_data_o <= ~ee_data_o;
		end
	end
endmodule

// >>> tb/testbench.sv
// Purpose: Self-checking bench of the ID/start block
// Assumes: Host port and EEPROM model on one 25 MHz clock
// Notes:   Short load timeout keeps the run brief
`timescale 1ns/1ps

module testbench;
	import switch_id_pkg::*;
	localparam logic [7:0] FAM = 8'hA7;  // Arbitrary value
	localparam logic [3:0] SER = 4'h5;   // Arbitrary value
	localparam logic [2:0] REV = 3'h3;   // Arbitrary value

	logic           clk, reset_n, ce, ack, absent, ready, en, applied, present, oerr;
	logic [1:0]     straps;
	logic [7:0]     edata, b0, b1, served;
	logic [9:0]     dly;
	access_req_type req;
	access_rsp_type rsp;
	ee_req_type     ereq;
	int             mismatches, n_checks, cycles;
	logic [7:0]     exp_d;

	switch_id_and_start_control #(.FAMILY_CODE(FAM), .SERIES_CODE(SER), .REVISION_CODE(REV),
		.LOAD_TIMEOUT_CYCLES(1000)) dut (.clk_i(clk), .reset_n_i(reset_n), .ce_i(ce),
		.serial_mode_straps_i(straps), .host_req_i(req), .host_ready_o(ready),
		.host_rsp_o(rsp), .ee_req_o(ereq), .ee_ack_i(ack), .ee_data_i(edata),
		.ee_absent_i(absent), .switch_enable_o(en), .eeprom_applied_o(applied));

	eeprom_model eeprom (.clk_i(clk), .reset_n_i(reset_n), .ee_req_i(ereq), .present_i(present),
		.delay_i(dly), .byte0_i(b0), .byte1_i(b1), .ee_ack_o(ack), .ee_data_o(edata),
		.ee_absent_o(absent), .served_o(served), .order_err_o(oerr));

	always #20 clk = ~clk;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic region_type exp_region(input logic [6:0] a);
		if (a < 7'h02) return REGION_CHIP_ID;
		if (a < 7'h0C) return REGION_GLOBAL;
		if (a < 7'h10) return REGION_RESERVED;
		if (a < 7'h60) return (a[3:0] >= 4'hE) ? REGION_PORT_STATUS : REGION_PORT_CTRL;
		if (a < 7'h68) return REGION_TOS;
		if (a < 7'h6E) return REGION_MAC;
		if (a < 7'h70) return REGION_IND_CTRL;
		if (a < 7'h79) return REGION_IND_DATA;
		if (a < 7'h7B) return REGION_DTEST_STAT;
		if (a < 7'h7D) return REGION_DTEST_CTRL;
		if (a < 7'h7F) return REGION_ATEST_CTRL;
		return REGION_ATEST_STAT;
	endfunction

	// Straps only change while reset is held, as the capture needs
	task automatic do_reset(input logic [1:0] mode);
		int i;
		@(negedge clk);
		reset_n = 1'h0;
		straps = mode;
		repeat (20) @(negedge clk);
		reset_n = 1'h1;
		check("enable after reset", 8'h00, {7'h00, en});
		i = 0;
		while (ready !== 1'h1 && i < 2000) begin
			@(negedge clk);
			i++;
		end
		check("ready", 8'h01, {7'h00, ready});
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge clk);
		req = '{1'h0, 1'h1, a, d};
		@(negedge clk);
		req = '0;
	endtask

	task automatic rd(input logic [6:0] a, input logic [7:0] exp);
		logic [7:0] exp_port;
		exp_port = (a >= 7'h10 && a < 7'h60) ? {5'h00, a[6:4]} : 8'h00;
		@(negedge clk);
		req = '{1'h1, 1'h0, a, 8'h00};
		@(negedge clk);
		req = '0;
		check("rvalid", 8'h01, {7'h00, rsp.rvalid});
		check("rdata", exp, rsp.rdata);
		check("region", {4'h0, exp_region(a)}, {4'h0, rsp.region});
		check("port", exp_port, {5'h00, rsp.port});
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			$display("ERROR cycle limit expected %0d seen %0d", 19999, cycles);
			end_sim();
		end
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		clk = 1'h0;
		reset_n = 1'h0;
		ce = 1'h1;
		straps = 2'h2;
		req = '0;
		present = 1'h1;
		dly = 10'h000;
		b0 = FAM;
		b1 = {SER, 4'h0};
		mismatches = 0;
		n_checks = 0;
		cycles = 0;
		do_reset(2'h2);
		check("enable held", 8'h00, {7'h00, en});
		rd(7'h00, FAM);
		rd(7'h01, {SER, REV, 1'h0});
		wr(7'h00, 8'h5A);
		wr(7'h01, 8'hFE);
		rd(7'h00, FAM);
		rd(7'h01, {SER, REV, 1'h0});
		check("enable held", 8'h00, {7'h00, en});
		wr(7'h01, 8'h01);
		check("enable on", 8'h01, {7'h00, en});
		rd(7'h01, {SER, REV, 1'h1});
		wr(7'h01, 8'h00);
		check("enable off", 8'h00, {7'h00, en});
		for (int i = 2; i < 128; i++) begin
			exp_d = (exp_region(i[6:0]) == REGION_RESERVED) ? 8'h00 : (8'hC3 ^ i[7:0]);
			wr(i[6:0], 8'hC3 ^ i[7:0]);
			rd(i[6:0], exp_d);
		end
		wr(7'h01, 8'h01);
		$display("test host strap done");
		do_reset(2'h1);
		rd(7'h01, {SER, REV, 1'h0});
		check("enable held", 8'h00, {7'h00, en});
		// Frozen clock enable must swallow the start write
		ce = 1'h0;
		wr(7'h01, 8'h01);
		check("enable frozen", 8'h00, {7'h00, en});
		ce = 1'h1;
		rd(7'h01, {SER, REV, 1'h0});
		wr(7'h01, 8'h01);
		check("enable on", 8'h01, {7'h00, en});
		$display("test reserved strap done");
		do_reset(2'h3);
		wr(7'h01, 8'h01);
		check("enable test mode", 8'h00, {7'h00, en});
		$display("test factory strap done");
		// Good, slow, bad family, bad series, absent, silent past the timeout
		for (int k = 0; k < 6; k++) begin
			present = (k != 4);
			dly = (k == 1) ? 10'h003 : ((k == 5) ? 10'h3FF : 10'h000);
			b0 = (k == 2) ? (FAM ^ 8'h01) : FAM;
			b1 = (k == 3) ? {SER ^ 4'h1, 4'h0} : {SER, 4'hB};
			do_reset(2'h0);
			check("enable auto", 8'h01, {7'h00, en});
			check("applied", {7'h00, k < 2}, {7'h00, applied});
			rd(7'h02, (k < 2) ? 8'h58 : 8'h00);
			rd(7'h6D, (k < 2) ? 8'h37 : 8'h00);
			rd(7'h6E, 8'h00);
			rd(7'h00, FAM);
			rd(7'h01, {SER, REV, 1'h0});
			if (k < 2) begin
				check("bytes read", 8'h6E, served);
				check("order", 8'h00, {7'h00, oerr});
			end
			$display("test eeprom case %0d done", k);
		end
		end_sim();
	end
endmodule
